/* design/smpc_pkg.sv */
package smpc_pkg;

   // Key values of the power-mode key register
   localparam logic [7:0] KEY_STOP = 8'h5A;
   localparam logic [7:0] KEY_SLEEP = 8'h0F;
   localparam logic [7:0] KEY_RESET = 8'h00;

   // Register byte addresses on the bus
   localparam logic [7:0] ADR_KEY = 8'h00;
   localparam logic [7:0] ADR_DIV = 8'h04;
   localparam logic [7:0] ADR_CTRL = 8'h08;
   localparam logic [7:0] ADR_STAT = 8'h0C;

   // Divider control: prescaler is 2 to the power (setting + 1)
   localparam int DIV_W = 3;
   localparam logic [DIV_W-1:0] DIV_RESET = 3'h7;

   // Clock control fields
   localparam int CTRL_SEL_SUB = 0;
   localparam int CTRL_MAIN_EN = 1;
   localparam int CTRL_SUB_EN = 2;
   localparam logic [7:0] CTRL_RESET = 8'h02;

   // Status fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_FROM_RST = 2;
   localparam int STAT_CNT_LSB = 8;
   localparam int STAT_WAKE_LSB = 16;

   // Interval timer count span
   localparam logic [7:0] BIT_START = 8'h00;
   localparam logic [7:0] BIT_END = 8'hFF;

   // Wake source positions
   localparam int WAKE_N = 6;
   localparam int WK_EXT = 0;
   localparam int WK_TIMER = 1;
   localparam int WK_WATCH = 2;
   localparam int WK_I2C = 3;
   localparam int WK_SERIAL = 4;
   localparam int WK_UART = 5;

   // Power modes
   typedef enum logic [1:0] {MS_RUN, MS_SLEEP, MS_STOP, MS_STABLE} smpc_mode_e;

endpackage : smpc_pkg

/* design/smpc_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module smpc_sync3
   import smpc_pkg::*;
#(
   parameter int W = 2
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Asynchronous levels and filtered result
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] levelOut
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } smpc_sync_s;

   smpc_sync_s s_ff;
   smpc_sync_s nxt_s;

   // Change accepted only when stages two and three agree
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.s1 = asyncIn;
      nxt_s.s2 = s_ff.s1;
      nxt_s.s3 = s_ff.s2;
      for (int i = 0; i < W; i++)
      begin
         if (s_ff.s2[i] == s_ff.s3[i])
         begin
            nxt_s.lvl[i] = s_ff.s3[i];
         end
      end
   end

   // Idle level is all ones, matching the released reset pin
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_ff <= '1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign levelOut = s_ff.lvl;

endmodule : smpc_sync3
`default_nettype wire

/* design/smpc_stab_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module smpc_stab_timer
   import smpc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic [DIV_W-1:0] divSel,
   // State
   output logic busy,
   output logic done,
   output logic [7:0] count
);

   typedef struct packed {
      logic busy;
      logic done;
      logic [7:0] pre;
      logic [7:0] cnt;
   } smpc_tmr_s;

   smpc_tmr_s s_ff;
   smpc_tmr_s nxt_s;
   logic [7:0] preLimit;

   // Prescaler wraps after 2^(div+1) clocks
   assign preLimit = 8'((9'h002 << divSel) - 9'h001);

   // One full 00..FF sweep, then a done pulse
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      if (start)
      begin
         nxt_s.busy = 1'b1;
         nxt_s.pre = 8'h00;
         nxt_s.cnt = BIT_START;
      end
      else if (s_ff.busy)
      begin
         if (s_ff.pre == preLimit)
         begin
            nxt_s.pre = 8'h00;
            if (s_ff.cnt == BIT_END)
            begin
               nxt_s.busy = 1'b0;
               nxt_s.done = 1'b1;
               nxt_s.cnt = BIT_START;
            end
            else
            begin
               nxt_s.cnt = s_ff.cnt + 8'h01;
            end
         end
         else
         begin
            nxt_s.pre = s_ff.pre + 8'h01;
         end
      end
   end

   // Power-on begins with a sweep already running
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_ff <= '{busy: 1'b1, done: 1'b0, pre: 8'h00, cnt: BIT_START};
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign busy = s_ff.busy;
   assign done = s_ff.done;
   assign count = s_ff.cnt;

endmodule : smpc_stab_timer
`default_nettype wire

/* design/smpc_top.sv */
// Overview of operation
// R01 - STOP entered only by stop instruction while key register holds 5AH.
// R02 - Software writes the key register as a whole byte, never bitwise.
// R03 - Software follows STOP with at least two no-operation instructions.
// R04 - External reset asserted only after supply is back, held long enough.
// R05 - Reset, external, timer, watch, I2C, serial or UART events end STOP.
// R06 - Reset wake returns control registers to defaults, RAM untouched.
// R07 - Interrupt wake with interrupt flag 1 vectors to the service routine.
// R08 - Interrupt wake with interrupt flag 0 resumes after STOP, no vector.
// R09 - On wake interval timer counts 00H to FFH; overflow resumes operation.
// R10 - Software sets timer prescaler so one sweep exceeds 20 ms.
// R11 - Stabilization lasts one full timer sweep, following the divider setting.
// R12 - After reset the divider is at default so delay cannot be shortened.
// R13 - STOP halts only the selected oscillator; the other keeps running.
// R14 - Watch timer on the running sub oscillator keeps counting and wakes.
// R15 - Key register clears itself on release from STOP.
// R16 - Writing 0Fh to the key register enters SLEEP; oscillators keep running.
// R17 - STOP instruction without the key value behaves as no operation.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module smpc_top
   import smpc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // CPU side
   input wire logic stopExec,
   input wire logic cpuIntFlag,
   output logic cpuHalt,
   output logic intVectorReq,
   output logic resumeNext,
   output logic ctrlResetPulse,
   // Wake sources on mclk, external pins asynchronous
   input wire logic [WAKE_N-1:0] wakeReq,
   input wire logic extIntPin,
   input wire logic rstPinN,
   // Oscillator enables
   output logic mainOscEn,
   output logic subOscEn
);

   typedef struct packed {
      smpc_mode_e mode;
      logic [7:0] key;
      logic [DIV_W-1:0] div;
      logic [7:0] ctrl;
      logic fromReset;
      logic [WAKE_N-1:0] wakeSrc;
      logic extPrev;
      logic rstPrev;
      logic tmrStart;
      logic ack;
      logic [31:0] rdat;
      logic halt;
      logic vecReq;
      logic resume;
      logic ctrlRst;
      logic mainEn;
      logic subEn;
   } smpc_top_s;

   smpc_top_s s_ff;
   smpc_top_s nxt_s;
   logic [1:0] pinLvl;
   logic tmrBusy;
   logic tmrDone;
   logic [7:0] tmrCount;
   logic extRise;
   logic rstFall;
   logic [WAKE_N-1:0] wakeVec;
   logic wakeAny;
   logic wbReq;
   logic keyWrite;

   // Word decode, shared by read and write paths
   function automatic logic regHit(input logic [7:0] adr, input logic [7:0] off);
      regHit = (adr[7:2] == off[7:2]);
   endfunction : regHit

   // Both pins are off-domain, so they pass the filter
   smpc_sync3 #(
      .W(2)
   ) u_pins (
      .mclk(mclk),
      .rst(rst),
      .asyncIn({rstPinN, extIntPin}),
      .levelOut(pinLvl)
   );

   // Stabilization sweep follows the live divider setting
   smpc_stab_timer u_tmr (
      .mclk(mclk),
      .rst(rst),
      .start(s_ff.tmrStart),
      .divSel(s_ff.div),
      .busy(tmrBusy),
      .done(tmrDone),
      .count(tmrCount)
   );

   // Pin edges and wake gathering
   assign extRise = pinLvl[0] & ~s_ff.extPrev;
   assign rstFall = ~pinLvl[1] & s_ff.rstPrev;
   assign wakeVec = {wakeReq[WAKE_N-1:1], wakeReq[WK_EXT] | extRise};
   assign wakeAny = |wakeVec; // [R05] [R14]
   assign wbReq = wb_cyc_i & wb_stb_i & ~s_ff.ack;
   assign keyWrite = wbReq & wb_we_i & wb_sel_i[0] & regHit(wb_adr_i, ADR_KEY);

   // Next-state logic for mode, registers and bus
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.ack = 1'b0;
      nxt_s.tmrStart = 1'b0;
      nxt_s.vecReq = 1'b0;
      nxt_s.resume = 1'b0;
      nxt_s.ctrlRst = 1'b0;
      nxt_s.extPrev = pinLvl[0];
      nxt_s.rstPrev = pinLvl[1];
      // Single-cycle answer; unmapped reads give zero
      if (wbReq)
      begin
         nxt_s.ack = 1'b1;
         nxt_s.rdat = 32'h00000000;
         if (regHit(wb_adr_i, ADR_KEY))
         begin
            nxt_s.rdat[7:0] = s_ff.key;
         end
         else if (regHit(wb_adr_i, ADR_DIV))
         begin
            nxt_s.rdat[DIV_W-1:0] = s_ff.div;
         end
         else if (regHit(wb_adr_i, ADR_CTRL))
         begin
            nxt_s.rdat[7:0] = s_ff.ctrl;
         end
         else if (regHit(wb_adr_i, ADR_STAT))
         begin
            nxt_s.rdat[STAT_MODE_LSB +: 2] = s_ff.mode;
            nxt_s.rdat[STAT_FROM_RST] = s_ff.fromReset;
            nxt_s.rdat[STAT_CNT_LSB +: 8] = tmrCount;
            nxt_s.rdat[STAT_WAKE_LSB +: WAKE_N] = s_ff.wakeSrc;
         end
         // Only lane 0 holds data; whole-byte store expected [R02]
         if (wb_we_i && wb_sel_i[0])
         begin
            if (regHit(wb_adr_i, ADR_KEY))
            begin
               nxt_s.key = wb_dat_i[7:0];
            end
            else if (regHit(wb_adr_i, ADR_DIV))
            begin
               nxt_s.div = wb_dat_i[DIV_W-1:0];
            end
            else if (regHit(wb_adr_i, ADR_CTRL))
            begin
               nxt_s.ctrl = wb_dat_i[7:0];
            end
         end
      end
      // Mode sequencing
      case (s_ff.mode)
         MS_RUN:
         begin
            if (keyWrite && wb_dat_i[7:0] == KEY_SLEEP)
            begin
               nxt_s.mode = MS_SLEEP; // [R16]
               nxt_s.halt = 1'b1;
            end
            else if (stopExec && s_ff.key == KEY_STOP)
            begin
               nxt_s.mode = MS_STOP; // [R01]
               nxt_s.halt = 1'b1;
            end
            // Unkeyed stop falls through untouched [R17]
         end
         MS_SLEEP, MS_STOP:
         begin
            if (wakeAny)
            begin
               nxt_s.mode = MS_STABLE; // [R05]
               nxt_s.tmrStart = 1'b1; // [R09]
               nxt_s.fromReset = 1'b0;
               nxt_s.wakeSrc = wakeVec;
            end
         end
         MS_STABLE:
         begin
            if (tmrDone)
            begin
               nxt_s.mode = MS_RUN; // [R09] [R11]
               nxt_s.halt = 1'b0;
               nxt_s.key = KEY_RESET; // [R15]
               nxt_s.vecReq = ~s_ff.fromReset & cpuIntFlag; // [R07]
               nxt_s.resume = ~s_ff.fromReset & ~cpuIntFlag; // [R08]
            end
         end
         default:
         begin
            nxt_s.mode = MS_RUN;
         end
      endcase
      // Reset pin wins over everything; divider back to default [R06] [R12]
      if (rstFall)
      begin
         nxt_s.key = KEY_RESET;
         nxt_s.div = DIV_RESET;
         nxt_s.ctrl = CTRL_RESET;
         nxt_s.mode = MS_STABLE;
         nxt_s.halt = 1'b1;
         nxt_s.fromReset = 1'b1;
         nxt_s.tmrStart = 1'b1;
         nxt_s.ctrlRst = 1'b1;
         nxt_s.vecReq = 1'b0;
         nxt_s.resume = 1'b0;
      end
      // Gate only the selected oscillator while stopped [R13] [R14]
      nxt_s.mainEn = nxt_s.ctrl[CTRL_MAIN_EN] & ~(nxt_s.mode == MS_STOP && !nxt_s.ctrl[CTRL_SEL_SUB]);
      nxt_s.subEn = nxt_s.ctrl[CTRL_SUB_EN] & ~(nxt_s.mode == MS_STOP && nxt_s.ctrl[CTRL_SEL_SUB]);
   end

   // Power-on counts as a reset wake with a running sweep
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_ff <= '0;
         s_ff.mode <= MS_STABLE;
         s_ff.div <= DIV_RESET;
         s_ff.ctrl <= CTRL_RESET;
         s_ff.fromReset <= 1'b1;
         s_ff.halt <= 1'b1;
         s_ff.extPrev <= 1'b1;
         s_ff.rstPrev <= 1'b1;
         s_ff.mainEn <= CTRL_RESET[CTRL_MAIN_EN];
         s_ff.subEn <= CTRL_RESET[CTRL_SUB_EN];
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from state flops
   assign wb_ack_o = s_ff.ack;
   assign wb_dat_o = s_ff.rdat;
   assign cpuHalt = s_ff.halt;
   assign intVectorReq = s_ff.vecReq;
   assign resumeNext = s_ff.resume;
   assign ctrlResetPulse = s_ff.ctrlRst;
   assign mainOscEn = s_ff.mainEn;
   assign subOscEn = s_ff.subEn;

   // Busy-cycle count of the current sweep, for checking only
   logic [16:0] sweepLen;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sweepLen <= 17'h00000;
      end
      else if (s_ff.tmrStart)
      begin
         sweepLen <= 17'h00000;
      end
      else if (tmrBusy)
      begin
         sweepLen <= sweepLen + 17'h00001;
      end
   end

   a_stop_keyed: assert property (@(posedge mclk) disable iff (rst) // [R01]
      (s_ff.mode == MS_RUN && stopExec && !keyWrite && !rstFall) |=>
      (s_ff.mode == (($past(s_ff.key) == KEY_STOP) ? MS_STOP : MS_RUN)))
      else $error("stop entry does not match key");

   a_stop_nop: assert property (@(posedge mclk) disable iff (rst) // [R17]
      (s_ff.mode == MS_RUN && stopExec && s_ff.key != KEY_STOP && !keyWrite && !rstFall) |=>
      (!cpuHalt && mainOscEn == s_ff.ctrl[CTRL_MAIN_EN]))
      else $error("unkeyed stop changed clocks or halted");

   a_sleep_entry: assert property (@(posedge mclk) disable iff (rst) // [R16]
      (s_ff.mode == MS_RUN && keyWrite && wb_dat_i[7:0] == KEY_SLEEP && !rstFall) |=>
      (s_ff.mode == MS_SLEEP && cpuHalt && mainOscEn == s_ff.ctrl[CTRL_MAIN_EN]))
      else $error("sleep key did not enter sleep");

   a_wake_exit: assert property (@(posedge mclk) disable iff (rst) // [R05]
      ((s_ff.mode == MS_STOP || s_ff.mode == MS_SLEEP) && wakeAny && !rstFall) |=>
      (s_ff.mode == MS_STABLE && s_ff.tmrStart ##1 tmrBusy && tmrCount == BIT_START))
      else $error("wake event did not start stabilization");

   a_reset_regs: assert property (@(posedge mclk) disable iff (rst) // [R06] [R12]
      rstFall |=> (s_ff.key == KEY_RESET && s_ff.div == DIV_RESET && s_ff.ctrl == CTRL_RESET
      && ctrlResetPulse && cpuHalt))
      else $error("reset pin did not restore control registers");

   a_vector_req: assert property (@(posedge mclk) disable iff (rst) // [R07] [R08]
      (s_ff.mode == MS_STABLE && tmrDone && !s_ff.fromReset && !rstFall) |=>
      (intVectorReq == $past(cpuIntFlag) && resumeNext == !$past(cpuIntFlag) && !cpuHalt))
      else $error("resume path does not follow interrupt flag");

   a_key_clear: assert property (@(posedge mclk) disable iff (rst) // [R15]
      (s_ff.mode == MS_STABLE && tmrDone && !rstFall) |=> (s_ff.key == KEY_RESET && s_ff.mode == MS_RUN))
      else $error("key not cleared on release");

   a_osc_gate: assert property (@(posedge mclk) disable iff (rst) // [R13] [R14]
      (s_ff.mode == MS_STOP) |-> (s_ff.ctrl[CTRL_SEL_SUB] ?
      (!subOscEn && mainOscEn == s_ff.ctrl[CTRL_MAIN_EN]) :
      (!mainOscEn && subOscEn == s_ff.ctrl[CTRL_SUB_EN])))
      else $error("wrong oscillator gated in stop");

   a_sweep_len: assert property (@(posedge mclk) disable iff (rst) // [R09] [R11]
      (tmrDone && !s_ff.tmrStart) |-> (sweepLen == (17'h00100 << (4'(s_ff.div) + 4'h1))))
      else $error("stabilization length differs from one sweep");

endmodule : smpc_top
`default_nettype wire

/* tb/smpc_wake_model.sv */
`timescale 1ns/1ps
`default_nettype none
module smpc_wake_model
   import smpc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Requests from the bench
   input wire logic fire,
   input wire logic [2:0] srcSel,
   input wire logic slow,
   // Wake lines toward the block
   output logic [WAKE_N-1:0] wakeReq,
   output logic extIntPin,
   output logic rstPinN
);
   logic [2:0] holdCnt;
   logic [2:0] srcQ;

   // Source raises its line once, slow ones hold it for five cycles
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         holdCnt <= 3'h0;
         srcQ <= 3'h0;
      end
      else if (fire)
      begin
         holdCnt <= slow ? 3'h5 : 3'h1;
         srcQ <= srcSel;
      end
      else if (holdCnt != 3'h0)
      begin
         holdCnt <= holdCnt - 3'h1;
      end
   end

   // Index 6 is the interrupt pin, 7 the reset pin; both need the long hold to pass the filter
   always_comb
   begin
      wakeReq = '0;
      extIntPin = 1'b0;
      rstPinN = 1'b1;
      if (holdCnt != 3'h0 && srcQ < 3'h6)
      begin
         wakeReq[srcQ] = 1'b1;
      end
      if (holdCnt != 3'h0 && srcQ == 3'h6)
      begin
         extIntPin = 1'b1;
      end
      // Supply never dips here; low for five cycles, past the filter
      if (holdCnt != 3'h0 && srcQ == 3'h7)
      begin
         rstPinN = 1'b0;
      end
   end
endmodule : smpc_wake_model
`default_nettype wire

/* tb/stop_mode_power_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      testsRun++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module stop_mode_power_control_bench
   import smpc_pkg::*;
;
   logic mclk, rst, wbCyc, wbStb, wbWe, wbAck, stopExec, cpuIntFlag;
   logic cpuHalt, intVectorReq, resumeNext, ctrlResetPulse;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatI, wbDatO, rdat;
   logic [WAKE_N-1:0] wakeReq;
   logic extIntPin, rstPinN, mainOscEn, subOscEn, fire, slow;
   logic [2:0] srcSel;
   int failures, testsRun;

   smpc_top i_smpc_top (.mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_ack_o(wbAck), .wb_dat_o(wbDatO),
      .stopExec(stopExec), .cpuIntFlag(cpuIntFlag), .cpuHalt(cpuHalt), .intVectorReq(intVectorReq),
      .resumeNext(resumeNext), .ctrlResetPulse(ctrlResetPulse), .wakeReq(wakeReq),
      .extIntPin(extIntPin), .rstPinN(rstPinN), .mainOscEn(mainOscEn), .subOscEn(subOscEn));
   smpc_wake_model i_smpc_wake_model (.mclk(mclk), .rst(rst), .fire(fire), .srcSel(srcSel),
      .slow(slow), .wakeReq(wakeReq), .extIntPin(extIntPin), .rstPinN(rstPinN));

   // Free-running 100 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict

   task timeoutHit;
      failures++;
      $display("[FAIL] wait expected done seen timeout");
      print_verdict();
   endtask : timeoutHit

   // Classic single cycle; held until ack is sampled, whole word always
   task wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= 4'hF;
      wbDatI <= wd;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (wbAck !== 1'b1 && n < 100);
      if (n >= 100)
         timeoutHit();
      rdat = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wbXfer

   // Pulse the instruction, then two quiet cycles as the no-operation pair
   task pulseStop;
      @(posedge mclk);
      stopExec <= 1'b1;
      @(posedge mclk);
      stopExec <= 1'b0;
      @(posedge mclk);
      @(posedge mclk);
   endtask : pulseStop

   // Fire one wake source and time the stabilization sweep
   task wakeAndTime(input logic [2:0] src, input logic flag, input int sweep);
      int n;
      cpuIntFlag <= flag;
      @(posedge mclk);
      fire <= 1'b1;
      srcSel <= src;
      slow <= (src == 3'h6 || src == 3'h2);
      @(posedge mclk);
      fire <= 1'b0;
      n = 1;
      while (intVectorReq !== 1'b1 && resumeNext !== 1'b1 && n < 70000)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 70000)
         timeoutHit();
      `CHK("sweep length", 1'b1, (n >= sweep && n <= sweep + 16))
      `CHK("vector pulse", flag, intVectorReq)
      `CHK("resume pulse", !flag, resumeNext)
      `CHK("halt released", 1'b0, cpuHalt)
      @(posedge mclk);
      `CHK("single pulse", 1'b0, intVectorReq | resumeNext)
   endtask : wakeAndTime

   task testResetDefaults;
      int n;
      `CHK("halt at power-on", 1'b1, cpuHalt)
      wbXfer(1'b0, ADR_KEY, 32'h0);
      `CHK("key reset", {24'h0, KEY_RESET}, rdat)
      wbXfer(1'b0, ADR_DIV, 32'h0);
      `CHK("div reset", {29'h0, DIV_RESET}, rdat)
      wbXfer(1'b0, ADR_CTRL, 32'h0);
      `CHK("ctrl reset", {24'h0, CTRL_RESET}, rdat)
      wbXfer(1'b1, 8'h40, 32'hFF);
      wbXfer(1'b0, 8'h40, 32'h0);
      `CHK("unmapped read", 32'h0, rdat)
      n = 0;
      while (cpuHalt !== 1'b0 && n < 70000)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 70000)
         timeoutHit();
      `CHK("long sweep", 1'b1, (n >= 65536 - 64))
      `CHK("main osc on", 1'b1, mainOscEn)
      $display("test reset defaults done");
   endtask : testResetDefaults

   task testStopNoKey;
      wbXfer(1'b1, ADR_KEY, 32'h5B);
      pulseStop();
      `CHK("no halt without key", 1'b0, cpuHalt)
      `CHK("main osc kept", 1'b1, mainOscEn)
      $display("test stop without key done");
   endtask : testStopNoKey

   // Every wake source but the reset pin, both clock selections, both flag values
   task testStopWakeAll;
      logic sel;
      wbXfer(1'b1, ADR_DIV, 32'h0); // Short sweep keeps the run short
      for (int i = 0; i < 7; i++)
      begin
         sel = (i % 2 == 1);
         wbXfer(1'b1, ADR_CTRL, {29'h0, 2'h3, sel});
         wbXfer(1'b1, ADR_KEY, {24'h0, KEY_STOP});
         pulseStop();
         `CHK("stop halt", 1'b1, cpuHalt)
         `CHK("main osc in stop", sel, mainOscEn)
         `CHK("sub osc in stop", !sel, subOscEn)
         wakeAndTime(i[2:0], i[1], 512);
         wbXfer(1'b0, ADR_KEY, 32'h0);
         `CHK("key cleared", 32'h0, rdat)
      end
      $display("test stop wake sources done");
   endtask : testStopWakeAll

   task testSleep;
      wbXfer(1'b1, ADR_DIV, 32'h1);
      wbXfer(1'b1, ADR_KEY, {24'h0, KEY_SLEEP});
      @(posedge mclk);
      `CHK("sleep halt", 1'b1, cpuHalt)
      `CHK("sleep main osc", 1'b1, mainOscEn)
      `CHK("sleep sub osc", 1'b1, subOscEn)
      wakeAndTime(3'h3, 1'b1, 1024);
      $display("test sleep done");
   endtask : testSleep

   // Reset pin mid-run: defaults come back, the long sweep restarts
   task testResetPin;
      int n;
      wbXfer(1'b1, ADR_KEY, {24'h0, KEY_STOP});
      wbXfer(1'b1, ADR_CTRL, 32'h7);
      @(posedge mclk);
      fire <= 1'b1;
      srcSel <= 3'h7;
      slow <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      n = 0;
      while (ctrlResetPulse !== 1'b1 && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20)
         timeoutHit();
      `CHK("reset pulse", 1'b1, ctrlResetPulse)
      `CHK("halt on reset", 1'b1, cpuHalt)
      `CHK("main osc back", CTRL_RESET[CTRL_MAIN_EN], mainOscEn)
      @(posedge mclk);
      `CHK("reset pulse single", 1'b0, ctrlResetPulse)
      wbXfer(1'b0, ADR_KEY, 32'h0);
      `CHK("key after pin", {24'h0, KEY_RESET}, rdat)
      wbXfer(1'b0, ADR_DIV, 32'h0);
      `CHK("div after pin", {29'h0, DIV_RESET}, rdat)
      wbXfer(1'b0, ADR_CTRL, 32'h0);
      `CHK("ctrl after pin", {24'h0, CTRL_RESET}, rdat)
      wbXfer(1'b0, ADR_STAT, 32'h0);
      `CHK("mode after pin", MS_STABLE, rdat[STAT_MODE_LSB +: 2])
      `CHK("wake from reset", 1'b1, rdat[STAT_FROM_RST])
      `CHK("no resume on pin", 1'b0, intVectorReq | resumeNext)
      $display("test reset pin done");
   endtask : testResetPin

   // Main sequence
   initial
   begin
      failures = 0;
      testsRun = 0;
      rst = 1'b1;
      {wbCyc, wbStb, wbWe, stopExec, cpuIntFlag, fire, slow} = '0;
      wbAdr = 8'h00;
      wbSel = 4'h0;
      wbDatI = 32'h0;
      srcSel = 3'h0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      testResetDefaults();
      testStopNoKey();
      testStopWakeAll();
      testSleep();
      testResetPin();
      print_verdict();
   end
endmodule : stop_mode_power_control_bench
`default_nettype wire
